// ---- logic/cache_maintenance_op_decoder.sv ----
// Chosen here: the placing of the registers and strobed register access.
module cache_maintenance_op_decoder
    import cache_op_pkg::*;
#(
    parameter int CACHE_BYTES = CACHE_BYTES_DEF,
    parameter int SET_BITS    = $clog2(CACHE_BYTES / LINE_BYTES)
) (
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    // Command port from the core
    input  wire logic                     cmd_single_write,
    input  wire logic                     cmd_double_write,
    input  wire logic                     cmd_single_read,
    input  wire logic                     cmd_privileged,
    input  wire logic [2:0]               cmd_opcode1,
    input  wire logic [3:0]               minor_register_field,
    input  wire logic [2:0]               cmd_opcode2,
    input  wire logic [31:0]              cmd_data,
    input  wire logic [31:0]              cmd_data_hi,
    input  wire logic [31:0]              cmd_pc,
    input  wire logic                     irq_pending,
    // Status from the caches
    input  wire logic                     dcache_dirty,
    input  wire logic                     block_xfer_active,
    input  wire logic                     clean_walk_done,
    // Results to the core
    output logic                          cmd_stall,
    output logic                          cmd_undefined,
    output logic                          cmd_interrupted,
    output logic [31:0]                   link_register,
    output logic [31:0]                   read_data,
    output logic                          read_valid,
    // Cache side
    output logic                          cache_op_valid,
    output cache_op_t                     cache_op,
    output logic [1:0]                    cache_way,
    output logic [SET_BITS-1:0]           cache_set,
    output logic                          coupled_memory_select,
    output logic [26:0]                   line_address,
    output logic [31:0]                   range_start,
    output logic [31:0]                   range_end,
    output logic [6:0]                    btc_index,
    output logic                          btc_flush_all,
    output logic                          clean_walk_start,
    output logic                          clean_walk_abort,
    output logic                          clean_skip_emulating_tcm,
    output logic                          bypass_remap
);
    import cache_op_pkg::*;

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic        is_whole;
    logic        is_line;
    logic        is_nop;
    logic        is_range;
    logic        is_read;
    logic        legal;
    cache_op_t   dec_op;
    logic        dec_sw;
    logic        dec_btc;

    always_comb begin
        dec_op   = OP_NONE;
        dec_sw   = 1'b0;
        dec_btc  = 1'b0;
        is_whole = 1'b0;
        is_line  = 1'b0;
        is_nop   = 1'b0;
        is_range = 1'b0;
        is_read  = 1'b0;
        legal    = 1'b0;
        if (cmd_single_write && cmd_opcode1 == OP1_ZERO) begin
            case ({minor_register_field, cmd_opcode2})
                {CRM_INV_ICACHE, OP2_WHOLE}:  begin dec_op = OP_INV_I_ALL;   is_whole = 1'b1; end
                {CRM_INV_DCACHE, OP2_WHOLE}:  begin dec_op = OP_INV_D_ALL;   is_whole = 1'b1; end
                {CRM_INV_BOTH,   OP2_WHOLE}:  begin dec_op = OP_INV_BOTH;    is_whole = 1'b1; end
                {CRM_CLEAN_D,    OP2_WHOLE}:  begin dec_op = OP_CLEAN_D_ALL; is_whole = 1'b1; end
                {CRM_CLEAN_INV_D, OP2_WHOLE}: begin dec_op = OP_CLINV_D_ALL; is_whole = 1'b1; end
                {CRM_INV_ICACHE, OP2_MVA}:    begin dec_op = OP_INV_I_LINE;  is_line = 1'b1; end
                {CRM_INV_ICACHE, OP2_SETWAY}: begin dec_op = OP_INV_I_LINE;  dec_sw = 1'b1; end
                {CRM_INV_DCACHE, OP2_MVA}:    begin dec_op = OP_INV_D_LINE;  is_line = 1'b1; end
                {CRM_INV_DCACHE, OP2_SETWAY}: begin dec_op = OP_INV_D_LINE;  dec_sw = 1'b1; end
                {CRM_CLEAN_D,    OP2_MVA}:    begin dec_op = OP_CLEAN_LINE;  is_line = 1'b1; end
                {CRM_CLEAN_D,    OP2_SETWAY}: begin dec_op = OP_CLEAN_LINE;  dec_sw = 1'b1; end
                {CRM_PREFETCH_I, OP2_MVA}:    begin dec_op = OP_PREFETCH_I;  is_line = 1'b1; end
                {CRM_CLEAN_INV_D, OP2_MVA}:   begin dec_op = OP_CLINV_LINE;  is_line = 1'b1; end
                {CRM_CLEAN_INV_D, OP2_SETWAY}: begin dec_op = OP_CLINV_LINE; dec_sw = 1'b1; end
                {CRM_INV_ICACHE, 3'h6}:       begin dec_op = OP_BTC_ENTRY;   dec_btc = 1'b1; end
                default: begin
                    // Unified-cache encodings are privileged no-ops
                    if ((minor_register_field == CRM_INV_BOTH && cmd_opcode2 != OP2_WHOLE) ||
                        minor_register_field == CRM_UNIFIED_A ||
                        minor_register_field == CRM_UNIFIED_B) begin
                        is_nop = 1'b1;
                    end
                end
            endcase
            if (dec_op == OP_CLEAN_D_ALL || dec_op == OP_CLINV_D_ALL ||
                dec_op == OP_INV_BOTH || dec_op == OP_INV_I_ALL ||
                dec_op == OP_INV_D_ALL || dec_op == OP_INV_I_LINE ||
                dec_op == OP_INV_D_LINE || dec_op == OP_CLEAN_LINE ||
                dec_op == OP_CLINV_LINE || dec_op == OP_PREFETCH_I ||
                dec_op == OP_BTC_ENTRY) begin
                legal = cmd_privileged;
            end else begin
                legal = is_nop && cmd_privileged;
            end
        end else if (cmd_double_write) begin
            case ({cmd_opcode1, minor_register_field})
                {OP1_ZERO, CRM_INV_ICACHE}, {OP1_ZERO, CRM_INV_DCACHE},
                {OP1_ZERO, CRM_CLEAN_INV_D}: begin
                    is_range = 1'b1;
                    legal    = cmd_privileged;
                end
                {OP1_ZERO, CRM_RANGE_CLEAN}, {OP1_PREFETCH_I, CRM_RANGE_CLEAN},
                {OP1_PREFETCH_D, CRM_RANGE_CLEAN}: begin
                    is_range = 1'b1;
                    legal    = 1'b1;
                end
                default: begin
                    legal = 1'b1; // Other double writes are ignored
                end
            endcase
            dec_op = is_range ? OP_RANGE : OP_NONE;
        end else if (cmd_single_read) begin
            is_read = (cmd_opcode1 == OP1_ZERO) && (minor_register_field == CRM_CLEAN_D) &&
                      (cmd_opcode2 == OP2_DIRTY_READ);
            legal   = is_read && cmd_privileged;
        end
    end

    // ****************************************************************
    // Blocking clean sequencer
    // ****************************************************************
    walk_state_t state;
    walk_state_t next_state;
    logic        clean_cmd;
    logic        next_interrupted;
    logic [31:0] next_link;

    assign clean_cmd = legal && (dec_op == OP_CLEAN_D_ALL || dec_op == OP_CLINV_D_ALL);

    always_comb begin
        next_state       = state;
        next_interrupted = 1'b0;
        next_link        = link_register;
        case (state)
            ST_IDLE: begin
                if (clean_cmd) begin
                    next_state = ST_CLEAN;
                end
            end
            ST_CLEAN: begin
                if (clean_walk_done) begin
                    next_state = ST_DONE;
                end else if (irq_pending) begin
                    // Restart point is the next instruction slot
                    next_link        = cmd_pc + RETURN_OFFSET;
                    next_interrupted = 1'b1;
                    next_state       = ST_IDLE;
                end
            end
            ST_DONE: next_state = clean_cmd ? ST_CLEAN : ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state           <= ST_IDLE;
            cmd_interrupted <= 1'b0;
            link_register   <= 32'h0000_0000;
        end else begin
            state           <= next_state;
            cmd_interrupted <= next_interrupted;
            link_register   <= next_link;
        end
    end

    // Pipeline held while the walk runs; also on the issue cycle
    assign cmd_stall        = clean_cmd || state == ST_CLEAN;
    assign clean_walk_start = clean_cmd && state != ST_CLEAN;
    assign clean_walk_abort = state == ST_CLEAN && !clean_walk_done && irq_pending;

    // ****************************************************************
    // Command outputs
    // ****************************************************************
    logic                next_valid;
    cache_op_t           next_op;
    logic [1:0]          next_way;
    logic [SET_BITS-1:0] next_set;
    logic                next_sel;
    logic [26:0]         next_line;
    logic [6:0]          next_btc;
    logic                next_btc_all;
    logic                next_skip_tcm;
    logic [31:0]         next_rstart;
    logic [31:0]         next_rend;
    logic [31:0]         next_rdata;
    logic                next_rvalid;
    logic                next_undef;

    always_comb begin
        next_valid    = legal && dec_op != OP_NONE;
        next_op       = legal ? dec_op : OP_NONE;
        next_way      = cache_way;
        next_set      = cache_set;
        next_sel      = coupled_memory_select;
        next_line     = line_address;
        next_btc      = btc_index;
        next_btc_all  = legal && (dec_op == OP_INV_I_ALL || dec_op == OP_INV_BOTH);
        next_skip_tcm = legal && (dec_op == OP_CLEAN_D_ALL || dec_op == OP_CLINV_D_ALL);
        next_rstart   = range_start;
        next_rend     = range_end;
        next_rdata    = 32'h0000_0000;
        next_rvalid   = 1'b0;
        next_undef    = (cmd_single_write || cmd_double_write || cmd_single_read) && !legal;
        if (legal && dec_sw) begin
            next_way = cmd_data[WAY_HI:WAY_LO];
            next_set = cmd_data[SET_LO +: SET_BITS];
            next_sel = cmd_data[SEL_BIT];
        end
        if (legal && is_line) begin
            next_line = cmd_data[31:LINE_ADDR_LO];
        end
        if (legal && dec_btc) begin
            next_btc = cmd_data[BTC_ADDR_HI:BTC_ADDR_LO];
        end
        if (legal && is_range) begin
            next_rstart = {cmd_data[31:LINE_ADDR_LO], 5'b0_0000};
            next_rend   = {cmd_data_hi[31:LINE_ADDR_LO], 5'b0_0000};
        end
        if (legal && is_read) begin
            next_rdata  = {30'h0000_0000, block_xfer_active, dcache_dirty};
            next_rvalid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cache_op_valid           <= 1'b0;
            cache_op                 <= OP_NONE;
            cache_way                <= 2'b00;
            cache_set                <= '0;
            coupled_memory_select    <= 1'b0;
            line_address             <= 27'h000_0000;
            btc_index                <= 7'h00;
            btc_flush_all            <= 1'b0;
            clean_skip_emulating_tcm <= 1'b0;
            range_start              <= 32'h0000_0000;
            range_end                <= 32'h0000_0000;
            read_data                <= 32'h0000_0000;
            read_valid               <= 1'b0;
            cmd_undefined            <= 1'b0;
        end else begin
            cache_op_valid           <= next_valid;
            cache_op                 <= next_op;
            cache_way                <= next_way;
            cache_set                <= next_set;
            coupled_memory_select    <= next_sel;
            line_address             <= next_line;
            btc_index                <= next_btc;
            btc_flush_all            <= next_btc_all;
            clean_skip_emulating_tcm <= next_skip_tcm;
            range_start              <= next_rstart;
            range_end                <= next_rend;
            read_data                <= next_rdata;
            read_valid               <= next_rvalid;
            cmd_undefined            <= next_undef;
        end
    end

    // Maintenance addresses never go through process-id remapping
    assign bypass_remap = 1'b1;
endmodule : cache_maintenance_op_decoder

// ---- common/cache_op_pkg.sv ----
package cache_op_pkg;
    // ****************************************************************
    // Command field encodings
    // ****************************************************************
    localparam logic [3:0] CRM_INV_ICACHE  = 4'h5;
    localparam logic [3:0] CRM_INV_DCACHE  = 4'h6;
    localparam logic [3:0] CRM_INV_BOTH    = 4'h7;
    localparam logic [3:0] CRM_CLEAN_D     = 4'hA;
    localparam logic [3:0] CRM_UNIFIED_A   = 4'hB;
    localparam logic [3:0] CRM_RANGE_CLEAN = 4'hC;
    localparam logic [3:0] CRM_PREFETCH_I  = 4'hD;
    localparam logic [3:0] CRM_CLEAN_INV_D = 4'hE;
    localparam logic [3:0] CRM_UNIFIED_B   = 4'hF;
    localparam logic [2:0] OP2_WHOLE       = 3'h0;
    localparam logic [2:0] OP2_MVA         = 3'h1;
    localparam logic [2:0] OP2_SETWAY      = 3'h2;
    localparam logic [2:0] OP2_DIRTY_READ  = 3'h6;
    localparam logic [2:0] OP1_ZERO        = 3'h0;
    localparam logic [2:0] OP1_PREFETCH_I  = 3'h1;
    localparam logic [2:0] OP1_PREFETCH_D  = 3'h2;

    // ****************************************************************
    // Argument layouts
    // ****************************************************************
    localparam int WAY_HI        = 31;
    localparam int WAY_LO        = 30;
    localparam int SET_LO        = 5;
    localparam int SEL_BIT       = 0;
    localparam int LINE_BYTES    = 32;
    localparam int LINE_ADDR_LO  = 5;
    localparam int BTC_ADDR_LO   = 3;
    localparam int BTC_ADDR_HI   = 9;
    localparam logic [31:0] RETURN_OFFSET = 32'h0000_0004;
    localparam int CACHE_BYTES_DEF = 16384;

    // Operation codes delivered to the cache side
    typedef enum logic [3:0] {
        OP_NONE        = 4'b0000,
        OP_INV_I_ALL   = 4'b0001,
        OP_INV_D_ALL   = 4'b0010,
        OP_INV_BOTH    = 4'b0011,
        OP_CLEAN_D_ALL = 4'b0100,
        OP_CLINV_D_ALL = 4'b0101,
        OP_INV_I_LINE  = 4'b0110,
        OP_INV_D_LINE  = 4'b0111,
        OP_CLEAN_LINE  = 4'b1000,
        OP_CLINV_LINE  = 4'b1001,
        OP_PREFETCH_I  = 4'b1010,
        OP_BTC_ENTRY   = 4'b1011,
        OP_RANGE       = 4'b1100
    } cache_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CLEAN = 2'b01,
        ST_DONE  = 2'b10
    } walk_state_t;
endpackage : cache_op_pkg

// ---- tb/cache_maintenance_op_decoder_props.sv ----
module cache_op_props
    import cache_op_pkg::*;
#(
    parameter int SET_BITS = 9
) (
    input wire logic                ref_clk,
    input wire logic                srst,
    input wire logic                cmd_single_write,
    input wire logic                cmd_single_read,
    input wire logic                cmd_privileged,
    input wire logic [2:0]          cmd_opcode1,
    input wire logic [3:0]          minor_register_field,
    input wire logic [2:0]          cmd_opcode2,
    input wire logic [31:0]         cmd_data,
    input wire logic [31:0]         cmd_pc,
    input wire logic                dcache_dirty,
    input wire logic                cmd_stall,
    input wire logic                cmd_undefined,
    input wire logic                cmd_interrupted,
    input wire logic [31:0]         link_register,
    input wire logic [31:0]         read_data,
    input wire logic                read_valid,
    input wire logic                cache_op_valid,
    input wire cache_op_t           cache_op,
    input wire logic [1:0]          cache_way,
    input wire logic [SET_BITS-1:0] cache_set,
    input wire logic                coupled_memory_select,
    input wire logic [26:0]         line_address,
    input wire logic [6:0]          btc_index,
    input wire logic                btc_flush_all,
    input wire logic                clean_walk_start,
    input wire logic                clean_walk_abort,
    input wire logic                clean_skip_emulating_tcm
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    logic        wr0;
    logic [31:0] data_q;
    logic        sw_cmd;
    assign wr0 = cmd_single_write && cmd_privileged && cmd_opcode1 == OP1_ZERO;
    assign sw_cmd = minor_register_field inside {CRM_INV_ICACHE, CRM_INV_DCACHE,
                                                 CRM_CLEAN_D, CRM_CLEAN_INV_D};
    always_ff @(posedge ref_clk) begin
        data_q <= cmd_data;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // ****************************************************************
    // Properties
    // ****************************************************************
    sequence s_clean_cmd;
        wr0 && cmd_opcode2 == OP2_WHOLE
            && (minor_register_field == CRM_CLEAN_D || minor_register_field == CRM_CLEAN_INV_D);
    endsequence
    sequence s_clean_go;
        cmd_stall && clean_walk_start ##1 cache_op_valid && clean_skip_emulating_tcm && cmd_stall;
    endsequence
    property p_clean;
        s_clean_cmd |-> s_clean_go;
    endproperty
    a_clean: assert property (p_clean) else $error("clean walk not launched");
    property p_setway;
        wr0 && cmd_opcode2 == OP2_SETWAY && sw_cmd |=> cache_way == data_q[31:30]
            && cache_set == data_q[SET_BITS+4:5] && coupled_memory_select == data_q[0];
    endproperty
    a_setway: assert property (p_setway) else $error("set/way fields wrong");
    property p_line;
        wr0 && cmd_opcode2 == OP2_MVA && (sw_cmd || minor_register_field == CRM_PREFETCH_I)
            |=> line_address == data_q[31:5];
    endproperty
    a_line: assert property (p_line) else $error("line address wrong");
    property p_btc_entry;
        wr0 && minor_register_field == CRM_INV_ICACHE && cmd_opcode2 == 3'h6
            |=> btc_index == data_q[9:3];
    endproperty
    a_btc_entry: assert property (p_btc_entry) else $error("branch index wrong");
    property p_flush_all;
        wr0 && cmd_opcode2 == OP2_WHOLE && (minor_register_field == CRM_INV_ICACHE
            || minor_register_field == CRM_INV_BOTH) |=> btc_flush_all && cache_op_valid;
    endproperty
    a_flush_all: assert property (p_flush_all) else $error("branch cache not flushed");
    property p_dirty;
        cmd_single_read && cmd_privileged && minor_register_field == CRM_CLEAN_D
            && cmd_opcode2 == OP2_DIRTY_READ |=> read_valid && read_data[0] == $past(dcache_dirty);
    endproperty
    a_dirty: assert property (p_dirty) else $error("dirty status wrong");
    property p_abort;
        clean_walk_abort |=> cmd_interrupted && link_register == $past(cmd_pc) + RETURN_OFFSET;
    endproperty
    a_abort: assert property (p_abort) else $error("return address wrong");
    property p_undef;
        (cmd_single_write || cmd_single_read) && cmd_opcode1 == OP1_ZERO
            && (!cmd_privileged || minor_register_field == 4'h3)
            |=> cmd_undefined && !cache_op_valid;
    endproperty
    a_undef: assert property (p_undef) else $error("illegal access not refused");
endmodule : cache_op_props

bind cache_maintenance_op_decoder cache_op_props #(.SET_BITS(SET_BITS)) props_u (.*);

// ---- tb/cache_side_model.sv ----
module cache_side_model (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       clean_walk_start,
    input  wire logic       clean_walk_abort,
    input  wire logic [7:0] walk_len,
    output logic            dcache_dirty,
    output logic            clean_walk_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic       busy;
    // Cache starts dirty; only a walk that runs to its end cleans it
    always_ff @(posedge ref_clk) begin
        clean_walk_done <= 1'b0;
        if (srst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            dcache_dirty <= 1'b1;
        end else if (clean_walk_start) begin
            busy <= 1'b1;
            cnt <= 8'h00;
        end else if (clean_walk_abort) begin
            busy <= 1'b0;
        end else if (busy && cnt == walk_len) begin
            busy <= 1'b0;
            clean_walk_done <= 1'b1;
            dcache_dirty <= 1'b0;
        end else if (busy) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : cache_side_model

// ---- tb/cache_maintenance_op_decoder_bench.sv ----
module cache_maintenance_op_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cache_op_pkg::*;
    localparam int SB = 7;
    typedef struct packed {
        logic [3:0] m;
        logic [2:0] o2;
        logic [31:0] d;
        cache_op_t  op;
        logic       btc;
    } row_t;
    localparam row_t ROWS [13] = '{
        '{CRM_INV_ICACHE, OP2_WHOLE, 32'h0000_0000, OP_INV_I_ALL, 1'b1},
        '{CRM_INV_BOTH, OP2_WHOLE, 32'h0000_0000, OP_INV_BOTH, 1'b1},
        '{CRM_INV_DCACHE, OP2_WHOLE, 32'h0000_0000, OP_INV_D_ALL, 1'b0},
        '{CRM_INV_ICACHE, OP2_MVA, 32'hDEAD_BEEF, OP_INV_I_LINE, 1'b0},
        '{CRM_INV_DCACHE, OP2_MVA, 32'h1234_567F, OP_INV_D_LINE, 1'b0},
        '{CRM_CLEAN_D, OP2_MVA, 32'hFFFF_FFE0, OP_CLEAN_LINE, 1'b0},
        '{CRM_CLEAN_INV_D, OP2_MVA, 32'h8000_001F, OP_CLINV_LINE, 1'b0},
        '{CRM_PREFETCH_I, OP2_MVA, 32'h0000_0020, OP_PREFETCH_I, 1'b0},
        '{CRM_INV_ICACHE, 3'h6, 32'hFFFF_FC08, OP_BTC_ENTRY, 1'b0},
        '{CRM_INV_ICACHE, OP2_SETWAY, 32'h0000_0001, OP_INV_I_LINE, 1'b0},
        '{CRM_INV_DCACHE, OP2_SETWAY, 32'hFFFF_FFFF, OP_INV_D_LINE, 1'b0},
        '{CRM_CLEAN_D, OP2_SETWAY, 32'h8000_0FE0, OP_CLEAN_LINE, 1'b0},
        '{CRM_CLEAN_INV_D, OP2_SETWAY, 32'h4000_0020, OP_CLINV_LINE, 1'b0}
    };
    // Strobe kind {read, double, single}, privileged, minor, opcode2, undefined
    localparam logic [11:0] BAD [8] = '{
        {3'b001, 1'b1, 4'h3, 3'h0, 1'b1}, {3'b001, 1'b0, 4'h5, 3'h0, 1'b1},
        {3'b100, 1'b1, 4'h5, 3'h0, 1'b1}, {3'b001, 1'b1, 4'hB, 3'h3, 1'b0},
        {3'b001, 1'b1, 4'hF, 3'h7, 1'b0}, {3'b001, 1'b1, 4'h7, 3'h5, 1'b0},
        {3'b001, 1'b0, 4'hB, 3'h0, 1'b1}, {3'b010, 1'b1, 4'h9, 3'h0, 1'b0}
    };
    logic        ref_clk, srst, cmd_single_write, cmd_double_write, cmd_single_read;
    logic        cmd_privileged, irq_pending, block_xfer_active, dcache_dirty, clean_walk_done;
    logic [2:0]  cmd_opcode1, cmd_opcode2;
    logic [3:0]  minor_register_field;
    logic [31:0] cmd_data, cmd_data_hi, cmd_pc, link_register, read_data, range_start, range_end;
    logic [7:0]  walk_len;
    logic        cmd_stall, cmd_undefined, cmd_interrupted, read_valid, cache_op_valid;
    logic        coupled_memory_select, btc_flush_all, clean_walk_start, clean_walk_abort;
    logic        clean_skip_emulating_tcm, bypass_remap;
    cache_op_t   cache_op;
    logic [1:0]  cache_way;
    logic [SB-1:0] cache_set;
    logic [26:0] line_address;
    logic [6:0]  btc_index;
    int          err_count = 0, samples_checked = 0;
    cache_maintenance_op_decoder #(.CACHE_BYTES(4096)) dut_u (.*);
    cache_side_model model_u (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    // Command stands one cycle; results are looked at after the taking edge
    task automatic issue(input logic [2:0] k, input logic p, input logic [3:0] m,
                         input logic [2:0] o2, input logic [31:0] d);
        @(posedge ref_clk);
        {cmd_single_read, cmd_double_write, cmd_single_write} <= k;
        {cmd_privileged, minor_register_field, cmd_opcode2, cmd_data} <= {p, m, o2, d};
        @(posedge ref_clk);
        {cmd_single_read, cmd_double_write, cmd_single_write} <= 3'b000;
        #1;
    endtask : issue
    task automatic wait_idle();
        for (int n = 0; n < 40 && cmd_stall !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_idle
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200us;
        err_count++;
        end_of_test();
    end
    initial begin
        {cmd_single_write, cmd_double_write, cmd_single_read, cmd_privileged} = 4'h0;
        {cmd_opcode1, minor_register_field, cmd_opcode2, walk_len} = 18'h0_0000;
        {cmd_data, cmd_data_hi, cmd_pc, irq_pending, block_xfer_active} = 98'h0;
        srst = 1'b1;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk_val(32'(cache_op), 32'(OP_NONE));
        for (int i = 0; i < 13; i++) begin
            issue(3'b001, 1'b1, ROWS[i].m, ROWS[i].o2, ROWS[i].d);
            chk_flag(cache_op_valid, 1'b1);
            chk_val(32'(cache_op), 32'(ROWS[i].op));
            chk_flag(btc_flush_all, ROWS[i].btc);
            chk_flag(bypass_remap, 1'b1);
            if (ROWS[i].o2 == OP2_MVA)
                chk_val(32'(line_address), 32'(ROWS[i].d[31:5]));
            if (ROWS[i].o2 == 3'h6)
                chk_val(32'(btc_index), 32'(ROWS[i].d[9:3]));
            if (ROWS[i].o2 == OP2_SETWAY) begin
                chk_val(32'(cache_way), 32'(ROWS[i].d[31:30]));
                chk_val(32'(cache_set), 32'(ROWS[i].d[SB+4:5]));
                chk_flag(coupled_memory_select, ROWS[i].d[0]);
            end
        end
        for (int i = 0; i < 8; i++) begin
            issue(BAD[i][11:9], BAD[i][8], BAD[i][7:4], BAD[i][3:1], 32'h0000_0000);
            chk_flag(cmd_undefined, BAD[i][0]);
            chk_flag(cache_op_valid, 1'b0);
        end
        @(posedge ref_clk) cmd_data_hi <= 32'h0000_20FF;
        issue(3'b010, 1'b1, CRM_INV_DCACHE, 3'h0, 32'h0000_1234);
        chk_val(32'(cache_op), 32'(OP_RANGE));
        chk_val(range_start, 32'h0000_1220);
        chk_val(range_end, 32'h0000_20E0);
        // Back-to-back set/way writes, the second with every ignored bit low
        @(posedge ref_clk);
        cmd_single_write <= 1'b1;
        {minor_register_field, cmd_opcode2, cmd_data} <= {CRM_INV_DCACHE, OP2_SETWAY, 32'hC000_0FFF};
        @(posedge ref_clk);
        cmd_data <= 32'h0000_0040;
        #1;
        chk_val({cache_way, 25'(cache_set), 5'(coupled_memory_select)}, 32'hC000_0FE1);
        @(posedge ref_clk);
        cmd_single_write <= 1'b0;
        #1;
        chk_val({cache_way, 25'(cache_set), 5'(coupled_memory_select)}, 32'h0000_0040);
        @(posedge ref_clk) block_xfer_active <= 1'b1;
        issue(3'b100, 1'b1, CRM_CLEAN_D, OP2_DIRTY_READ, 32'h0000_0000);
        chk_flag(read_valid, 1'b1);
        chk_val(read_data & 32'h0000_0003, 32'h0000_0003);
        // Interrupt in mid-walk, then a restart that completes
        walk_len <= 8'd20;
        @(posedge ref_clk) cmd_pc <= 32'h0000_2468;
        issue(3'b001, 1'b1, CRM_CLEAN_INV_D, OP2_WHOLE, 32'h0000_0000);
        chk_val(32'(cache_op), 32'(OP_CLINV_D_ALL));
        chk_flag(clean_skip_emulating_tcm, 1'b1);
        chk_flag(cmd_stall, 1'b1);
        @(posedge ref_clk) irq_pending <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk_flag(cmd_interrupted, 1'b1);
        chk_val(link_register, 32'h0000_246C);
        @(posedge ref_clk) irq_pending <= 1'b0;
        wait_idle();
        chk_flag(cmd_stall, 1'b0);
        @(posedge ref_clk) block_xfer_active <= 1'b0;
        issue(3'b100, 1'b1, CRM_CLEAN_D, OP2_DIRTY_READ, 32'h0000_0000);
        chk_val(read_data & 32'h0000_0003, 32'h0000_0001);
        walk_len <= 8'd3;
        issue(3'b001, 1'b1, CRM_CLEAN_D, OP2_WHOLE, 32'h0000_0000);
        chk_val(32'(cache_op), 32'(OP_CLEAN_D_ALL));
        chk_flag(clean_skip_emulating_tcm, 1'b1);
        wait_idle();
        chk_flag(cmd_stall, 1'b0);
        chk_val(link_register, 32'h0000_246C);
        issue(3'b100, 1'b1, CRM_CLEAN_D, OP2_DIRTY_READ, 32'h0000_0000);
        chk_val(read_data & 32'h0000_0003, 32'h0000_0000);
        end_of_test();
    end
endmodule : cache_maintenance_op_decoder_bench
